// ==== logic/pmf_pkg.sv ====
// How it works
// - simple methods: bit0 parity, bit1 pre-error, bit2 one, bit3 residual; flag rule
// - combined method: bit2 burst failed, bit3 random failed; flag only on real error
// - without detailed status, 4-bit nibble is 0,1,1,flag
// - too many errors: no correction, status and flag set directly
// - combined method with too many errors reports status code F
// - matched address in lock mode starts sending the following message
// - shift clock runs at 2x, 8x, 16x or 32x the data rate
// - address byte: function bits, slot, detailed status bits, bit7 error flag without detail
// - address error bit set for matched but uncorrectable address
// - bypassed codeword gives three bytes, packed codeword gives five
// - 7/8 packing puts flag in bit7; 4-bit packing puts status high
// - bypassed bytes carry M0-M7, M8-M15, then M16-M19 with status
// - termination byte is 0x04 plus flag; alphanumeric first sends the flag alone in bit7, then a plain 0x04
// - detect pin polarity selectable; held without detail, pulsed with detail
// - no termination byte when packing is bypassed
// - unconverted codewords split into bytes, last nibble joined with status
// - single-bit fix forces one-bit method status for message words
package pmf_pkg;
   // register map
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   localparam int CTRL_W = 10;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;
   localparam int CTRL_RATE_LO = 0;
   localparam int CTRL_RATE_HI = 1;
   localparam int CTRL_BYPASS = 2;
   localparam int CTRL_DETAIL = 3;
   localparam int CTRL_POL = 4;
   localparam int CTRL_SINGLE_FIX = 5;
   localparam int CTRL_METH_LO = 6;
   localparam int CTRL_METH_HI = 7;
   localparam int CTRL_PACK4 = 8;
   localparam int CTRL_ALPHA = 9;
   localparam int STAT_BUSY = 0;
   localparam int STAT_INMSG = 1;
   localparam int STAT_CNT_LO = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // correction methods
   localparam logic [1:0] METH_RANDOM2 = 2'h0;
   localparam logic [1:0] METH_COMBINED = 2'h1;
   localparam logic [1:0] METH_BURST = 2'h2;
   localparam logic [1:0] METH_ONE = 2'h3;
   // codeword kinds from the decoder
   localparam logic [1:0] KIND_ADDR = 2'h0;
   localparam logic [1:0] KIND_MSG = 2'h1;
   localparam logic [1:0] KIND_END = 2'h2;
   // word contents
   localparam logic [6:0] TERM_WORD = 7'h04;
   localparam logic [3:0] MODE_F = 4'hf;
   localparam logic [2:0] NODETAIL_LOW3 = 3'h6;
   localparam logic [2:0] BYTES_BYPASS = 3'h3;
   localparam logic [2:0] BYTES_PACK = 3'h5;
   localparam logic [2:0] BYTES_ONE = 3'h1;
   localparam logic [2:0] BYTES_ALPHA_END = 3'h2;
   localparam logic [3:0] LAST_HALF = 4'hf;
   // timing
   localparam int CLK_HZ = 25_000_000;
   localparam int BIT_RATE_HZ = 1200;
   localparam int ADDR_PULSE_NS = 1000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int ADDR_PULSE_CYC = (ADDR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MULT_00 = 2;
   localparam int MULT_01 = 8;
   localparam int MULT_10 = 16;
   localparam int MULT_11 = 32;
   typedef enum logic [1:0] {FMT_IDLE = 2'b01, FMT_EMIT = 2'b10} pmf_fmt_state_type;
   typedef enum logic [1:0] {SER_IDLE = 2'b01, SER_SHIFT = 2'b10} pmf_ser_state_type;
endpackage

// ==== logic/pmf_byte_buf.sv ====
`timescale 1ns/1ps
module pmf_byte_buf #(
   parameter int WIDTH = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_r [2];
   logic rd_ptr_r;
   logic wr_ptr_r;
   logic [1:0] count_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count_r != 2'h2);
   assign out_valid = (count_r != 2'h0);
   assign out_data = mem_r[rd_ptr_r];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr_r <= 1'b0;
         wr_ptr_r <= 1'b0;
         count_r <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= ~wr_ptr_r;
         end
         if (pop) begin
            rd_ptr_r <= ~rd_ptr_r;
         end
         count_r <= count_r + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge aclk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end
endmodule // pmf_byte_buf

// ==== logic/pmf_formatter_top.sv ====
`timescale 1ns/1ps
module pmf_formatter_top import pmf_pkg::*; #(
   parameter int BIT_PERIOD_CYC = CLK_HZ / BIT_RATE_HZ
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // codewords from the decoder
   input wire logic lock_mode,
   input wire logic cw_valid,
   output logic cw_ready,
   input wire logic [1:0] cw_kind,
   input wire logic [1:0] cw_slot,
   input wire logic [19:0] cw_bits,
   input wire logic cw_par_err,
   input wire logic cw_rnd_pre,
   input wire logic cw_rnd_post,
   input wire logic cw_bst_pre,
   input wire logic cw_bst_post,
   input wire logic cw_too_many,
   // pins to the host
   output logic out_serial_data,
   output logic shift_clock,
   output logic address_detect_pin
);
   localparam logic [15:0] HALF_00 = 16'(BIT_PERIOD_CYC / (2 * MULT_00));
   localparam logic [15:0] HALF_01 = 16'(BIT_PERIOD_CYC / (2 * MULT_01));
   localparam logic [15:0] HALF_10 = 16'(BIT_PERIOD_CYC / (2 * MULT_10));
   localparam logic [15:0] HALF_11 = 16'(BIT_PERIOD_CYC / (2 * MULT_11));
   localparam logic [7:0] PULSE_CYC = 8'(ADDR_PULSE_CYC);

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   logic [CTRL_W-1:0] ctrl_r;
   logic [3:0] awaddr_r;
   logic aw_hold_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic w_hold_r;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [7:0] sent_cnt_r;
   logic in_msg_r;
   pmf_ser_state_type ser_state_r;

   wire aw_take = awvalid && awready_r;
   wire w_take = wvalid && wready_r;
   wire wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
   wire wr_hit = (awaddr_r == ADDR_CTRL);
   wire ar_take = arvalid && arready_r;
   wire rd_ctrl = (araddr == ADDR_CTRL);
   wire rd_stat = (araddr == ADDR_STAT);
   wire [31:0] stat_word = ({24'h0, sent_cnt_r} << STAT_CNT_LO)
      | ({31'h0, ser_state_r == SER_SHIFT} << STAT_BUSY)
      | ({31'h0, in_msg_r} << STAT_INMSG);
   wire [31:0] rd_word = rd_ctrl ? {{(32-CTRL_W){1'b0}}, ctrl_r} :
      (rd_stat ? stat_word : 32'h0);
   wire [CTRL_W-1:0] ctrl_wr = {wstrb_r[1] ? wdata_r[CTRL_W-1:8] : ctrl_r[CTRL_W-1:8],
      wstrb_r[0] ? wdata_r[7:0] : ctrl_r[7:0]};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0;
         wstrb_r <= 4'h0;
         ctrl_r <= CTRL_RESET;
      end else begin
         if (aw_take) begin
            aw_hold_r <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r <= awaddr;
         end
         if (w_take) begin
            w_hold_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            if (wr_hit) begin
               ctrl_r <= ctrl_wr;
            end
         end
         if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= RESP_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rdata_r <= rd_word;
         rresp_r <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // ----------------------------------------
   // error status of the incoming codeword
   // ----------------------------------------
   wire [1:0] meth_cfg = ctrl_r[CTRL_METH_HI:CTRL_METH_LO];
   wire msg_kind = (cw_kind == KIND_MSG);
   // message words may be held to one-bit correction while addresses are not
   wire [1:0] meth_eff = (msg_kind && ctrl_r[CTRL_SINGLE_FIX]) ? METH_ONE : meth_cfg;
   wire is_comb = (meth_eff == METH_COMBINED);
   wire pre_err = cw_rnd_pre || cw_bst_pre;
   wire simple_post = cw_rnd_post || cw_bst_post;
   wire simple_flag = pre_err && (cw_par_err || simple_post);
   wire comb_flag = pre_err && (cw_par_err || cw_bst_post || cw_rnd_post);
   wire [3:0] simple_st = {simple_post, 1'b1, pre_err, cw_par_err};
   wire [3:0] comb_st = {cw_rnd_post, cw_bst_post, pre_err, cw_par_err};
   // too many errors bypass correction and report the worst case
   wire cw_flag = cw_too_many || (is_comb ? comb_flag : simple_flag);
   wire [3:0] cw_st = cw_too_many ? MODE_F : (is_comb ? comb_st : simple_st);
   wire addr_uncorr = cw_too_many || simple_post;

   // ----------------------------------------
   // formatter
   // ----------------------------------------
   pmf_fmt_state_type fmt_state_r;
   logic cw_ready_r;
   logic [1:0] kind_r, slot_r;
   logic [19:0] bits_r;
   logic [3:0] st_r;
   logic flag_r, uncorr_r, last_flag_r;
   logic bypass_r, detail_r, pack4_r, alpha_r;
   logic [2:0] nbytes_r, idx_r;
   logic buf_in_ready, buf_out_valid;
   logic [7:0] buf_out_data;

   wire cw_take = cw_valid && cw_ready_r;
   wire addr_ok = (cw_kind == KIND_ADDR) && lock_mode;
   wire msg_ok = msg_kind && in_msg_r;
   wire end_ok = (cw_kind == KIND_END) && in_msg_r;
   wire bypass = ctrl_r[CTRL_BYPASS];
   wire [2:0] msg_n = bypass ? BYTES_BYPASS : BYTES_PACK;
   // bypassed messages end without a termination byte
   wire [2:0] end_n = bypass ? 3'h0 : (ctrl_r[CTRL_ALPHA] ? BYTES_ALPHA_END : BYTES_ONE);
   wire [2:0] take_n = addr_ok ? BYTES_ONE : (msg_ok ? msg_n : (end_ok ? end_n : 3'h0));
   wire [3:0] st_out = detail_r ? st_r : {flag_r, NODETAIL_LOW3};
   wire [19:0] nib_sh = bits_r >> {idx_r, 2'b00};
   wire [3:0] nib = nib_sh[3:0];
   // bit6 tells whether correction left an error, not the fixed status bit
   wire [2:0] addr_st = detail_r ? {uncorr_r, st_r[1:0]} : 3'h0;
   wire [7:0] addr_byte = {!detail_r && uncorr_r, addr_st, slot_r, bits_r[1:0]};
   wire [7:0] byp_byte = (idx_r == 3'h0) ? bits_r[7:0] :
      ((idx_r == 3'h1) ? bits_r[15:8] : {st_out, bits_r[19:16]});
   wire [7:0] pack_byte = pack4_r ? {st_out, nib} : {flag_r, 3'h0, nib};
   wire [7:0] end_byte = (alpha_r && (idx_r == 3'h0)) ? {last_flag_r, 7'h00} :
      {alpha_r ? 1'b0 : last_flag_r, TERM_WORD};
   wire [7:0] push_data = (kind_r == KIND_ADDR) ? addr_byte :
      ((kind_r == KIND_MSG) ? (bypass_r ? byp_byte : pack_byte) : end_byte);
   wire push_valid = (fmt_state_r == FMT_EMIT);
   wire push_take = push_valid && buf_in_ready;
   wire push_last = push_take && (idx_r == nbytes_r - 3'h1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fmt_state_r <= FMT_IDLE;
         cw_ready_r <= 1'b1;
         idx_r <= 3'h0;
         nbytes_r <= 3'h0;
         in_msg_r <= 1'b0;
         last_flag_r <= 1'b0;
      end else begin
         case (fmt_state_r)
            FMT_IDLE: begin
               if (cw_take && (take_n != 3'h0)) begin
                  fmt_state_r <= FMT_EMIT;
                  cw_ready_r <= 1'b0;
                  idx_r <= 3'h0;
                  nbytes_r <= take_n;
               end
               if (cw_take && addr_ok) begin
                  in_msg_r <= 1'b1;
               end else if (cw_take && end_ok) begin
                  in_msg_r <= 1'b0;
               end
               if (cw_take && msg_ok) begin
                  last_flag_r <= cw_flag;
               end
            end
            FMT_EMIT: begin
               if (push_last) begin
                  fmt_state_r <= FMT_IDLE;
                  cw_ready_r <= 1'b1;
               end else if (push_take) begin
                  idx_r <= idx_r + 3'h1;
               end
            end
            default: begin
               fmt_state_r <= FMT_IDLE;
               cw_ready_r <= 1'b1;
            end
         endcase
      end
   end

   // codeword held while its bytes go out; its format config is frozen with it, the shift rate is not
   always_ff @(posedge aclk) begin
      if (cw_take) begin
         kind_r <= cw_kind;
         slot_r <= cw_slot;
         bits_r <= cw_bits;
         st_r <= cw_st;
         flag_r <= cw_flag;
         uncorr_r <= addr_uncorr;
         bypass_r <= bypass;
         detail_r <= ctrl_r[CTRL_DETAIL];
         pack4_r <= ctrl_r[CTRL_PACK4];
         alpha_r <= ctrl_r[CTRL_ALPHA];
      end
   end

   assign cw_ready = cw_ready_r;

   // ----------------------------------------
   // two-entry byte buffer
   // ----------------------------------------
   wire ser_ready = (ser_state_r == SER_IDLE);

   pmf_byte_buf #(.WIDTH(8)) u_buf (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(push_valid),
      .in_ready(buf_in_ready),
      .in_data(push_data),
      .out_valid(buf_out_valid),
      .out_ready(ser_ready),
      .out_data(buf_out_data)
   );

   // ----------------------------------------
   // serializer
   // ----------------------------------------
   logic [7:0] sh_r;
   logic [3:0] half_idx_r;
   logic [15:0] tick_r;
   logic sclk_r, sdata_r;
   wire [1:0] rate_sel = {ctrl_r[CTRL_RATE_HI], ctrl_r[CTRL_RATE_LO]};
   wire [15:0] half_sel = (rate_sel == 2'h0) ? HALF_00 : ((rate_sel == 2'h1) ? HALF_01 :
      ((rate_sel == 2'h2) ? HALF_10 : HALF_11));
   // a very short bit period must still give at least one cycle per half
   wire [15:0] half_cyc = (half_sel == 16'h0) ? 16'h1 : half_sel;
   wire half_end = (tick_r == half_cyc - 16'h1);
   wire [3:0] half_nxt = half_idx_r + 4'h1;
   wire ser_load = ser_ready && buf_out_valid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ser_state_r <= SER_IDLE;
         sh_r <= 8'h00;
         half_idx_r <= 4'h0;
         tick_r <= 16'h0;
         sclk_r <= 1'b0;
         sdata_r <= 1'b0;
         sent_cnt_r <= 8'h00;
      end else begin
         case (ser_state_r)
            SER_IDLE: begin
               if (ser_load) begin
                  ser_state_r <= SER_SHIFT;
                  sh_r <= buf_out_data;
                  half_idx_r <= 4'h0;
                  tick_r <= 16'h0;
                  sdata_r <= buf_out_data[0];
               end
            end
            SER_SHIFT: begin
               if (!half_end) begin
                  tick_r <= tick_r + 16'h1;
               end else if (half_idx_r == LAST_HALF) begin
                  ser_state_r <= SER_IDLE;
                  sclk_r <= 1'b0;
                  sent_cnt_r <= sent_cnt_r + 8'h01;
               end else begin
                  // data moves only with the falling clock, host samples rising
                  tick_r <= 16'h0;
                  half_idx_r <= half_nxt;
                  sclk_r <= half_nxt[0];
                  sdata_r <= sh_r[half_nxt[3:1]];
               end
            end
            default: begin
               ser_state_r <= SER_IDLE;
            end
         endcase
      end
   end

   assign shift_clock = sclk_r;
   assign out_serial_data = sdata_r;

   // ----------------------------------------
   // address detect pin
   // ----------------------------------------
   logic [7:0] pulse_r;
   logic hold_r, pin_r;
   wire addr_seen = cw_take && addr_ok;
   wire det_active = hold_r || (pulse_r != 8'h00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pulse_r <= 8'h00;
         hold_r <= 1'b0;
         pin_r <= 1'b1;
      end else begin
         if (addr_seen && ctrl_r[CTRL_DETAIL]) begin
            pulse_r <= PULSE_CYC;
         end else if (pulse_r != 8'h00) begin
            pulse_r <= pulse_r - 8'h01;
         end
         if (addr_seen && !ctrl_r[CTRL_DETAIL]) begin
            hold_r <= 1'b1;
         end else if (cw_take && end_ok) begin
            hold_r <= 1'b0;
         end
         pin_r <= ctrl_r[CTRL_POL] ? det_active : !det_active;
      end
   end

   assign address_detect_pin = pin_r;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   data_on_fall_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (ser_state_r == SER_SHIFT) && $changed(sdata_r) |-> !sclk_r)
      else $error("serial data moved while shift clock high");
   term_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
      push_valid && (kind_r == KIND_END) |-> bypass_r == 1'b0)
      else $error("termination byte sent with packing bypassed");
   term_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
      push_valid && (kind_r == KIND_END) && !alpha_r |-> push_data[6:0] == TERM_WORD)
      else $error("termination byte has wrong code");
   nodetail_nib_a: assert property (@(posedge aclk) disable iff (!aresetn)
      push_valid && (kind_r == KIND_MSG) && pack4_r && !detail_r && !bypass_r
      |-> push_data[7:4] == {flag_r, NODETAIL_LOW3})
      else $error("status nibble wrong without detail");
   mode_f_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cw_take && cw_too_many |=> (st_r == MODE_F) && flag_r)
      else $error("too many errors not reported as code F");
   simple_st_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cw_take && !is_comb && !cw_too_many |=> st_r[2] && (st_r[0] == $past(cw_par_err)))
      else $error("simple method status bits wrong");
   addr_byte_a: assert property (@(posedge aclk) disable iff (!aresetn)
      push_valid && (kind_r == KIND_ADDR)
      |-> (push_data[3:2] == slot_r) && (push_data[7] == (!detail_r && uncorr_r)))
      else $error("address byte layout wrong");
   byte_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cw_take && msg_ok |=> nbytes_r == (bypass_r ? BYTES_BYPASS : BYTES_PACK))
      else $error("wrong number of bytes per codeword");
   pin_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
      addr_seen && ctrl_r[CTRL_DETAIL] && $stable(ctrl_r) |-> ##2 (pin_r == ctrl_r[CTRL_POL]))
      else $error("detect pin not active after address");
endmodule // pmf_formatter_top

// ==== testbench/pmf_host_model.sv ====
`timescale 1ns/1ps
module pmf_host_model (
   // pins from the device
   input wire logic aclk,
   input wire logic shift_clock,
   input wire logic out_serial_data
);
   logic [7:0] got [0:63];
   logic [7:0] sh_r = 8'h00;
   logic prev_r = 1'b0;
   int n_got = 0;
   int nbit = 0;
   int hcnt = 0;
   int hi_len = 0;
   // a slow host: finds the link's edges by oversampling
   always @(posedge aclk) begin
      prev_r <= shift_clock;
      hcnt <= (shift_clock == prev_r) ? hcnt + 1 : 1;
      if (!shift_clock && prev_r) hi_len <= hcnt;
      if (shift_clock && !prev_r) begin
         sh_r = {out_serial_data, sh_r[7:1]};
         nbit = nbit + 1;
         if (nbit == 8) begin
            got[n_got % 64] = sh_r;
            n_got = n_got + 1;
            nbit = 0;
         end
      end
   end
endmodule // pmf_host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
   import pmf_pkg::*;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [3:0] awaddr = 0, araddr = 0, wstrb = 4'hf;
   logic [31:0] wdata = 0;
   logic lock_mode = 0, cw_valid = 0, cw_par_err = 0, cw_rnd_pre = 0, cw_rnd_post = 0;
   logic cw_bst_pre = 0, cw_bst_post = 0, cw_too_many = 0;
   logic [1:0] cw_kind = 0, cw_slot = 0;
   logic [19:0] cw_bits = 0;
   logic awready, wready, bvalid, arready, rvalid, cw_ready;
   logic out_serial_data, shift_clock, address_detect_pin;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int num_errors = 0, n_compared = 0, nb = 0;
   // ----------------------------------------
   // device and host
   // ----------------------------------------
   pmf_formatter_top #(.BIT_PERIOD_CYC(64)) u_dut (.aclk, .aresetn,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .lock_mode, .cw_valid, .cw_ready, .cw_kind, .cw_slot, .cw_bits, .cw_par_err, .cw_rnd_pre,
      .cw_rnd_post, .cw_bst_pre, .cw_bst_post, .cw_too_many,
      .out_serial_data, .shift_clock, .address_detect_pin);
   pmf_host_model u_host (.aclk, .shift_clock, .out_serial_data);
   initial forever #20 aclk = ~aclk;
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk(rdata, ed);
      chk(rresp, er);
   endtask
   // error bits in order: parity, rnd pre, rnd post, burst pre, burst post, too many
   task automatic cw(input logic [1:0] k, input logic [1:0] s, input logic [19:0] b,
                     input logic [5:0] e);
      @(posedge aclk);
      cw_valid <= 1'b1;
      cw_kind <= k;
      cw_slot <= s;
      cw_bits <= b;
      {cw_par_err, cw_rnd_pre, cw_rnd_post, cw_bst_pre, cw_bst_post, cw_too_many} <= e;
      do @(posedge aclk); while (!cw_ready);
      cw_valid <= 1'b0;
      cw_bits <= ~b;
   endtask
   task automatic got_b(input int n, input logic [63:0] e);
      int t;
      t = 0;
      while (u_host.n_got < nb + n && t < 20000) begin
         @(posedge aclk);
         t++;
      end
      if (t == 20000) begin
         num_errors++;
         $display("BAD %0t timeout waiting for bytes", $time);
      end
      for (int i = 0; i < n; i++) chk(u_host.got[(nb + i) % 64], e[8*i +: 8]);
      nb += n;
   endtask
   task automatic quiet();
      repeat (600) @(posedge aclk);
      chk(u_host.n_got, nb);
   endtask
   task automatic pin_cnt(input logic lvl, input int exp);
      int n;
      n = 0;
      repeat (40) begin
         @(posedge aclk);
         if (address_detect_pin === lvl) n++;
      end
      chk(n, exp);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd(ADDR_CTRL, 32'h0, RESP_OKAY);
      wr(4'h8, 32'h3ff, RESP_SLVERR);
      rd(4'h8, 32'h0, RESP_SLVERR);
      rd(ADDR_CTRL, 32'h0, RESP_OKAY);
      chk(address_detect_pin, 1'b1);
      cw(KIND_ADDR, 2'h3, 20'h0, 6'h00);
      quiet();
      $display("done: registers and lock");
   endtask
   task automatic t_bypass();
      wr(ADDR_CTRL, 32'h00c, RESP_OKAY);
      rd(ADDR_CTRL, 32'h00c, RESP_OKAY);
      lock_mode <= 1'b1;
      cw(KIND_ADDR, 2'h3, 20'h1, 6'b110000);
      pin_cnt(1'b0, 25);
      got_b(1, 64'h3d);
      cw(KIND_MSG, 2'h0, 20'h93c5a, 6'h00);
      got_b(3, 64'h493c5a);
      cw(KIND_END, 2'h0, 20'h0, 6'h00);
      quiet();
      rd(ADDR_STAT, 32'h400, RESP_OKAY);
      chk(u_host.hi_len, 16);
      $display("done: bypass");
   endtask
   task automatic t_pack4();
      wr(ADDR_CTRL, 32'h101, RESP_OKAY);
      cw(KIND_ADDR, 2'h0, 20'h0, 6'b011001);
      got_b(1, 64'h80);
      cw(KIND_MSG, 2'h0, 20'h12345, 6'b011000);
      got_b(5, 64'he1e2e3e4e5);
      chk(address_detect_pin, 1'b0);
      cw(KIND_END, 2'h0, 20'h0, 6'h00);
      repeat (4) @(posedge aclk);
      chk(address_detect_pin, 1'b1);
      got_b(1, 64'h84);
      chk(u_host.hi_len, 4);
      $display("done: four-bit packing");
   endtask
   task automatic t_comb();
      wr(ADDR_CTRL, 32'h15a, RESP_OKAY);
      cw(KIND_ADDR, 2'h3, 20'h0, 6'h00);
      pin_cnt(1'b1, 25);
      got_b(1, 64'h0c);
      cw(KIND_MSG, 2'h0, 20'h0, 6'b011100);
      got_b(5, 64'ha0a0a0a0a0);
      cw(KIND_MSG, 2'h0, 20'h1, 6'b000001);
      got_b(5, 64'hf0f0f0f0f1);
      wr(ADDR_CTRL, 32'h17a, RESP_OKAY);
      cw(KIND_MSG, 2'h0, 20'h0, 6'b011100);
      got_b(5, 64'he0e0e0e0e0);
      chk(u_host.hi_len, 2);
      $display("done: combined method");
   endtask
   task automatic t_alpha();
      wr(ADDR_CTRL, 32'h203, RESP_OKAY);
      cw(KIND_ADDR, 2'h0, 20'h0, 6'h00);
      got_b(1, 64'h00);
      cw(KIND_MSG, 2'h0, 20'h7, 6'b011000);
      got_b(5, 64'h8080808087);
      cw(KIND_END, 2'h0, 20'h0, 6'h00);
      got_b(2, 64'h0480);
      chk(u_host.hi_len, 1);
      $display("done: alphanumeric end");
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_bypass();
      t_pack4();
      t_comb();
      t_alpha();
      end_of_test();
   end
   // tests need well under 0.5 ms at this link rate
   initial begin
      #1_000_000;
      num_errors++;
      end_of_test();
   end
endmodule // tb
